/* bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  // Time base and the wire as seen
  input wire logic clock_in,
  input wire logic sda_wire_in,
  // Pins; a high SDA level releases the line to its pull-up
  output logic scl_out,
  output logic sda_rel_out
);
  logic slow;
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
    slow = 1'b0;
  end
  // Five core cycles a quarter bit, twelve when slow, keeps each phase above the pin sampler's minimum.
  task automatic q;
    repeat (slow ? 12 : 5) @(negedge clock_in);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_rel_out = b;
    q();
    scl_out = 1'b1;
    q();
    s = sda_wire_in;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic start;
    sda_rel_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_rel_out = 1'b0;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic stop;
    sda_rel_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_rel_out = 1'b1;
    q();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!more, s);
  endtask
endmodule
`default_nettype wire

/* eeprom_pkg.sv */
`default_nettype none

package eeprom_pkg;

  // Array organisation.
  localparam int ADDR_W = 12;
  localparam int MEM_BYTES = 4096;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_BITS = 5;
  localparam int ROW_BITS = 7;
  localparam int WORD_HI_BITS = 4;
  localparam logic [11:0] ADDR_RESET = 12'h000;

  // Device-address byte fields.
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam int DEV_CODE_LSB = 4;
  localparam int DEV_SEL_LSB = 1;
  localparam logic READ_DIR = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Positions of the pin inputs inside the link-side synchroniser bundle.
  localparam int LINK_IN_W = 7;
  localparam int SCL_POS = 0;
  localparam int SDA_POS = 1;
  localparam int SEL_POS = 2;
  localparam int WP_POS = 5;
  localparam int DONE_POS = 6;

  // Self-timed write duration.
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

/* eeprom_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_sva #(
  parameter int unsigned WRITE_CYCLES = 50
) (
  // Clocks and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Straps and status
  input wire logic [2:0] chip_select_pins_in,
  input wire logic write_protect_in,
  input wire logic write_busy_out
);
  int busy_len;
  always_ff @(posedge clock_in) begin
    busy_len <= (rst_n_in && write_busy_out) ? busy_len + 1 : 0;
  end
  a_drive_low: assert property (
    @(posedge link_clk_in) disable iff (!rst_n_in) sda_out == 1'b0)
    else $error("sda_out drives high");
  a_ack_on_low: assert property (
    @(posedge link_clk_in) disable iff (!rst_n_in) $rose(sda_oe_out) |-> !scl_in)
    else $error("drive started while SCL high");
  a_release_on_low: assert property (
    @(posedge link_clk_in) disable iff (!rst_n_in) $fell(sda_oe_out) |-> !scl_in)
    else $error("drive released while SCL high");
  a_hold_scl_high: assert property (
    @(posedge link_clk_in) disable iff (!rst_n_in)
    scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("SDA drive changed while SCL high");
  a_busy_quiet: assert property (
    @(posedge link_clk_in) disable iff (!rst_n_in) write_busy_out |-> !sda_oe_out)
    else $error("bus driven during write cycle");
  a_wp_no_write: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    write_protect_in && $past(write_protect_in, 8) |-> !$rose(write_busy_out))
    else $error("write cycle started under write protect");
  a_busy_min: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    $fell(write_busy_out) |-> busy_len >= WRITE_CYCLES)
    else $error("write cycle too short");
  a_busy_max: assert property (
    @(posedge clock_in) disable iff (!rst_n_in) busy_len <= WRITE_CYCLES + 100)
    else $error("write cycle too long");
  c_busy: cover property (@(posedge clock_in) $rose(write_busy_out));
  c_ack: cover property (@(posedge link_clk_in) $rose(sda_oe_out) && !scl_in);
  c_wp: cover property (@(posedge clock_in) write_protect_in && !write_busy_out);
endmodule
bind serial_eeprom eeprom_sva #(.WRITE_CYCLES(WRITE_CYCLES)) eeprom_sva_inst (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .chip_select_pins_in(chip_select_pins_in), .write_protect_in(write_protect_in),
  .write_busy_out(write_busy_out));
`default_nettype wire

/* serial_eeprom.sv */
// How it works
// - Page write accepts up to 32 data bytes before the STOP.
// - Device acknowledges low on the ninth clock after each data byte.
// - Only the low five address bits advance per data byte.
// - Beyond 32 bytes the in-page address wraps and overwrites earlier bytes.
// - While programming runs, device-address bytes get no acknowledge.
// - Once programming ends, a valid device-address byte is acknowledged again.
// - Read uses the same device-address byte with direction bit set to one.
// - Address counter holds the last read address plus one, or the last written address plus one within its page.
// - Current-address read: ack, eight data bits from counter, counter plus one.
// - A read ended by no-acknowledge and STOP returns to standby.
// - Each master ack in a sequential read brings the next byte.
// - Reads wrap the counter from the top of the array to zero.
// - Random read is a dummy write of the address, then a current read.
// - START before any write data cancels the write and keeps the address.
// - Bus is ignored during power-on reset; release enters standby.
// - Device byte must start 1010 and match chip-select pins, else standby.
// - Word address is twelve bits in two bytes; upper spare bits ignored.
// - After the write STOP, bus inputs are ignored until programming ends.
// - Write-protect high suppresses programming; reads are unaffected.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  // Clocks and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Straps
  input wire logic [2:0] chip_select_pins_in,
  input wire logic write_protect_in,
  // Status
  output logic write_busy_out
);

  // Link-side protocol states. Each acknowledge state but rd_ack, which releases, holds the line low from the falling
  // edge after the eighth bit to the falling edge after the ninth, so the master sees a
  // steady level across the whole high phase of its ninth clock.
  typedef enum logic [3:0] {
    idle,
    dev_addr,
    dev_ack,
    word_hi,
    hi_ack,
    word_lo,
    lo_ack,
    wr_data,
    data_ack,
    rd_data,
    rd_ack
  } link_state_t;

  // Received bytes wait in a page buffer and reach the array only after STOP. This costs
  // 32 bytes of flops but lets a repeated START discard a write without touching the array.
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic scl_q;
    logic sda_q;
    link_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic read_dir;
    logic master_acked;
    logic [11:0] addr;
    logic [31:0][7:0] page_data;
    logic [31:0] mask;
    logic pend;
    logic start_tgl;
    logic done_seen;
    logic commit_on;
    logic [4:0] commit_idx;
    logic [6:0] commit_row;
    logic oe;
    logic sda_lvl;
  } link_regs_t;

  link_regs_t cur;
  link_regs_t next_cur;

  // The array lives in the link domain, so reads need no crossing.
  logic [7:0] mem [eeprom_pkg::MEM_BYTES];
  logic [7:0] mem_rd;

  logic [eeprom_pkg::LINK_IN_W-1:0] raw_pins;
  logic [eeprom_pkg::LINK_IN_W-1:0] pins;
  logic done_tgl;
  logic scl;
  logic sda;
  logic [2:0] sel;
  logic wp;
  logic done_now;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;

  assign raw_pins = {done_tgl, write_protect_in, chip_select_pins_in, sda_in, scl_in};

  // Every pin edge is seen about four link clocks late. The master must therefore keep
  // each clock phase and each data setup well above that latency, or bits are missed.
  // The done toggle shares this bundle because it is just another foreign level.
  sync3 #(
    .WIDTH(eeprom_pkg::LINK_IN_W)
  ) u_pin_sync (
    .clock_in(link_clk_in),
    .rst_n_in(cur.rst_sync),
    .async_in(raw_pins),
    .sync_out(pins)
  );

  // The timer runs on the core clock. Start and done travel as toggles, never as pulses,
  // so neither can be lost whatever the phase relation of the two clocks is.
  // The busy hold on the bus is released only once the done toggle has come back.
  write_timer #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .start_toggle_in(cur.start_tgl),
    .done_toggle_out(done_tgl),
    .busy_out(write_busy_out)
  );

  assign scl = pins[eeprom_pkg::SCL_POS];
  assign sda = pins[eeprom_pkg::SDA_POS];
  assign sel = pins[eeprom_pkg::SEL_POS +: 3];
  assign wp = pins[eeprom_pkg::WP_POS];
  assign done_now = pins[eeprom_pkg::DONE_POS];

  // START and STOP are only recognised while the clock line stays high for two samples.
  // A data change in the low phase therefore can never be mistaken for either condition.
  assign scl_rise = scl & ~cur.scl_q;
  assign scl_fall = ~scl & cur.scl_q;
  assign start_cond = scl & cur.scl_q & cur.sda_q & ~sda;
  assign stop_cond = scl & cur.scl_q & ~cur.sda_q & sda;

  assign mem_rd = mem[cur.addr];

  assign addr_match = (cur.shreg[7:eeprom_pkg::DEV_CODE_LSB] == eeprom_pkg::DEV_CODE)
    && (cur.shreg[eeprom_pkg::DEV_SEL_LSB +: 3] == sel)
    && !cur.pend && !cur.commit_on;

  always_comb begin
    next_cur = cur;
    next_cur.rst_meta = rst_n_in;
    next_cur.rst_sync = cur.rst_meta;
    next_cur.scl_q = scl;
    next_cur.sda_q = sda;
    next_cur.sda_lvl = 1'b0;

    // The timer's done toggle clears the busy hold on the bus.
    if (done_now != cur.done_seen) begin
      next_cur.done_seen = done_now;
      next_cur.pend = 1'b0;
    end

    // Buffered page bytes move into the array one per link clock.
    if (cur.commit_on) begin
      next_cur.commit_idx = cur.commit_idx + 5'h01;
      if (cur.commit_idx == 5'h1f) begin
        next_cur.commit_on = 1'b0;
        next_cur.mask = '0;
      end
    end

    if (start_cond) begin
      // A fresh START discards unprogrammed data but keeps the counter.
      next_cur.state = dev_addr;
      next_cur.bitcnt = '0;
      next_cur.oe = 1'b0;
      next_cur.master_acked = 1'b0;
      if (!cur.commit_on) begin
        next_cur.mask = '0;
      end
    end else if (stop_cond) begin
      next_cur.state = idle;
      next_cur.oe = 1'b0;
      if (!cur.commit_on && !cur.pend) begin
        if ((cur.mask != '0) && !wp) begin
          next_cur.commit_on = 1'b1;
          next_cur.commit_idx = '0;
          next_cur.commit_row = cur.addr[11:eeprom_pkg::PAGE_BITS];
          next_cur.pend = 1'b1;
          next_cur.start_tgl = ~cur.start_tgl;
        end else begin
          next_cur.mask = '0;
        end
      end
    end else begin
      case (cur.state)
        dev_addr, word_hi, word_lo, wr_data: begin
          if (scl_rise) begin
            next_cur.shreg = {cur.shreg[6:0], sda};
            next_cur.bitcnt = cur.bitcnt + 4'h1;
          end
          if (scl_fall && (cur.bitcnt == eeprom_pkg::BITS_PER_BYTE)) begin
            next_cur.bitcnt = '0;
            if (cur.state == dev_addr) begin
              if (addr_match) begin
                next_cur.oe = 1'b1;
                next_cur.read_dir = (cur.shreg[0] == eeprom_pkg::READ_DIR);
                next_cur.state = dev_ack;
              end else begin
                next_cur.state = idle;
              end
            end else if (cur.state == word_hi) begin
              next_cur.addr[11:8] = cur.shreg[eeprom_pkg::WORD_HI_BITS-1:0];
              next_cur.oe = 1'b1;
              next_cur.state = hi_ack;
            end else if (cur.state == word_lo) begin
              next_cur.addr[7:0] = cur.shreg;
              next_cur.oe = 1'b1;
              next_cur.state = lo_ack;
            end else begin
              // Later bytes of the same slot replace earlier ones.
              next_cur.page_data[cur.addr[4:0]] = cur.shreg;
              next_cur.mask[cur.addr[4:0]] = 1'b1;
              next_cur.addr[4:0] = cur.addr[4:0] + 5'h01;
              next_cur.oe = 1'b1;
              next_cur.state = data_ack;
            end
          end
        end
        dev_ack: begin
          if (scl_fall) begin
            if (cur.read_dir) begin
              next_cur.tx = mem_rd;
              next_cur.oe = ~mem_rd[7];
              next_cur.bitcnt = 4'h1;
              next_cur.state = rd_data;
            end else begin
              next_cur.oe = 1'b0;
              next_cur.state = word_hi;
            end
          end
        end
        hi_ack: begin
          if (scl_fall) begin
            next_cur.oe = 1'b0;
            next_cur.state = word_lo;
          end
        end
        lo_ack, data_ack: begin
          if (scl_fall) begin
            next_cur.oe = 1'b0;
            next_cur.state = wr_data;
          end
        end
        rd_data: begin
          // Each bit is put on the line right after a falling edge, so it is settled well
          // before the master samples it on the following rising edge.
          if (scl_fall) begin
            if (cur.bitcnt == eeprom_pkg::BITS_PER_BYTE) begin
              next_cur.oe = 1'b0;
              next_cur.bitcnt = '0;
              // The twelve-bit counter wraps naturally at the top of the array.
              next_cur.addr = cur.addr + 12'h001;
              next_cur.master_acked = 1'b0;
              next_cur.state = rd_ack;
            end else begin
              next_cur.tx = {cur.tx[6:0], 1'b0};
              next_cur.oe = ~cur.tx[6];
              next_cur.bitcnt = cur.bitcnt + 4'h1;
            end
          end
        end
        rd_ack: begin
          // The master's answer is taken on the rising edge; the next byte only starts on
          // the falling edge, so a no-acknowledge never gets a bit driven after it.
          if (scl_rise) begin
            if (sda) begin
              next_cur.state = idle;
            end else begin
              next_cur.master_acked = 1'b1;
            end
          end
          if (scl_fall && cur.master_acked) begin
            next_cur.tx = mem_rd;
            next_cur.oe = ~mem_rd[7];
            next_cur.bitcnt = 4'h1;
            next_cur.master_acked = 1'b0;
            next_cur.state = rd_data;
          end
        end
        idle: begin
          next_cur.oe = 1'b0;
        end
        default: begin
          next_cur.state = idle;
          next_cur.oe = 1'b0;
        end
      endcase
    end

    // Held in reset the bus is ignored and the line released.
    // The reset synchroniser itself keeps running so that release is seen cleanly.
    // The array is not cleared; its contents stay unknown until written.
    if (!cur.rst_sync) begin
      next_cur = '0;
      next_cur.rst_meta = rst_n_in;
      next_cur.rst_sync = cur.rst_meta;
      next_cur.addr = eeprom_pkg::ADDR_RESET;
      next_cur.state = idle;
    end
  end

  always_ff @(posedge link_clk_in) begin
    cur <= next_cur;
  end

  // Only bytes received in this transaction are programmed; the rest of the row stays.
  // The copy takes 32 link clocks, far below the timer, so it always ends before busy does.
  // Write protect is applied when the copy would start, not per byte.
  always_ff @(posedge link_clk_in) begin
    if (cur.commit_on && cur.mask[cur.commit_idx]) begin
      mem[{cur.commit_row, cur.commit_idx}] <= cur.page_data[cur.commit_idx];
    end
  end

  assign sda_out = cur.sda_lvl;
  assign sda_oe_out = cur.oe;

endmodule

`default_nettype wire

/* sync3.sv */
`timescale 1ns/1ps
`default_nettype none

module sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Asynchronous levels and their settled copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] mid;
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] settled;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;
  logic [WIDTH-1:0] agreed;

  // A bit only moves once the second and third stages hold the same value.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign agreed[i] = (cur.mid[i] == cur.last[i]) ? cur.last[i] : cur.settled[i];
  end

  always_comb begin
    next_cur = cur;
    next_cur.meta = async_in;
    next_cur.mid = cur.meta;
    next_cur.last = cur.mid;
    next_cur.settled = agreed;
    if (!rst_n_in) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    cur <= next_cur;
  end

  assign sync_out = cur.settled;

endmodule

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] WR = {eeprom_pkg::DEV_CODE, 3'b101, 1'b0};
  localparam logic [7:0] RD = WR | 8'h01;
  logic clock_in = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  logic scl, rel, oe, sdo, busy, ack;
  logic [7:0] d;
  wire logic sda = rel && !oe;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clock_in = ~clock_in;
  initial #1.7 forever #3 link_clk = ~link_clk;
  serial_eeprom #(.WRITE_CYCLES(400)) serial_eeprom_inst (.clock_in(clock_in),
    .rst_n_in(rst_n), .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sdo), .sda_oe_out(oe), .chip_select_pins_in(3'b101),
    .write_protect_in(wp), .write_busy_out(busy));
  bus_master bus_master_inst (.clock_in(clock_in), .sda_wire_in(sda), .scl_out(scl),
    .sda_rel_out(rel));
  task automatic complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Spare high address bits are sent as ones so that they must be ignored.
  task automatic addr(input logic [11:0] a);
    bus_master_inst.start();
    bus_master_inst.put_byte(WR, ack);
    chk("dev ack", 1, ack);
    bus_master_inst.put_byte({4'hf, a[11:8]}, ack);
    chk("hi ack", 1, ack);
    bus_master_inst.put_byte(a[7:0], ack);
    chk("lo ack", 1, ack);
  endtask
  task automatic rd_start(input logic [11:0] a);
    addr(a);
    bus_master_inst.start();
    bus_master_inst.put_byte(RD, ack);
    chk("read ack", 1, ack);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] b[$]);
    addr(a);
    foreach (b[i]) begin
      bus_master_inst.put_byte(b[i], ack);
      chk("data ack", 1, ack);
    end
    bus_master_inst.stop();
    repeat (20) @(negedge clock_in);
    chk("busy", 1, busy);
  endtask
  task automatic settle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge clock_in);
      n++;
    end
    chk("busy end", 0, busy);
    repeat (20) @(negedge clock_in);
  endtask
  task automatic t_page;
    logic [7:0] b[$];
    for (int i = 0; i < 34; i++) b.push_back(8'h10 + 8'(i));
    wr(12'h07e, b);
    bus_master_inst.start();
    bus_master_inst.put_byte(RD, ack);
    chk("poll busy", 0, ack);
    bus_master_inst.stop();
    settle();
    bus_master_inst.start();
    bus_master_inst.put_byte(RD, ack);
    chk("poll done", 1, ack);
    bus_master_inst.get_byte(1'b0, d);
    bus_master_inst.stop();
    chk("current", 8'h12, d);
    rd_start(12'h060);
    // Bytes 32 and 33 overwrite the first two slots written, so slot s holds byte s plus two.
    for (int s = 0; s < 32; s++) begin
      bus_master_inst.get_byte(s < 31, d);
      chk("page slot", 8'h10 + 8'(s + 2), d);
    end
    bus_master_inst.stop();
  endtask
  task automatic t_wrap;
    wr(12'hffe, '{8'ha5, 8'h5a});
    settle();
    wr(12'h000, '{8'hc3});
    settle();
    rd_start(12'hffe);
    bus_master_inst.get_byte(1'b1, d);
    chk("seq 0", 8'ha5, d);
    bus_master_inst.get_byte(1'b1, d);
    chk("seq 1", 8'h5a, d);
    bus_master_inst.get_byte(1'b0, d);
    chk("seq wrap", 8'hc3, d);
    bus_master_inst.stop();
  endtask
  task automatic t_reset;
    rst_n = 1'b0;
    bus_master_inst.start();
    bus_master_inst.put_byte(RD, ack);
    chk("reset ack", 0, ack);
    bus_master_inst.stop();
    rst_n = 1'b1;
    repeat (20) @(negedge clock_in);
    bus_master_inst.start();
    bus_master_inst.put_byte(RD, ack);
    bus_master_inst.get_byte(1'b0, d);
    bus_master_inst.stop();
    chk("after reset", 8'hc3, d);
  endtask
  task automatic t_wp;
    wp = 1'b1;
    repeat (10) @(negedge clock_in);
    addr(12'h000);
    bus_master_inst.put_byte(8'h99, ack);
    chk("wp ack", 1, ack);
    bus_master_inst.stop();
    repeat (40) @(negedge clock_in);
    chk("wp busy", 0, busy);
    wp = 1'b0;
  endtask
  task automatic t_refuse;
    bus_master_inst.start();
    bus_master_inst.put_byte({eeprom_pkg::DEV_CODE, 3'b100, 1'b0}, ack);
    chk("wrong sel", 0, ack);
    bus_master_inst.stop();
    bus_master_inst.start();
    bus_master_inst.put_byte({4'hb, 3'b101, 1'b0}, ack);
    chk("wrong code", 0, ack);
    bus_master_inst.stop();
    addr(12'h123);
    bus_master_inst.stop();
    repeat (40) @(negedge clock_in);
    chk("addr only", 0, busy);
  endtask
  initial begin
    repeat (8) @(negedge clock_in);
    rst_n = 1'b1;
    repeat (20) @(negedge clock_in);
    t_page();
    t_wrap();
    t_reset();
    t_wp();
    bus_master_inst.slow = 1'b1;
    rd_start(12'h000);
    bus_master_inst.get_byte(1'b0, d);
    bus_master_inst.stop();
    chk("wp keep", 8'hc3, d);
    bus_master_inst.slow = 1'b0;
    t_refuse();
    complete_run();
  end
endmodule
`default_nettype wire

/* write_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module write_timer #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  // Core clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Handshake with the link domain
  input wire logic start_toggle_in,
  output logic done_toggle_out,
  // Status
  output logic busy_out
);

  localparam int CW = $clog2(WRITE_CYCLES + 1);

  typedef struct packed {
    logic seen;
    logic busy;
    logic done;
    logic [CW-1:0] count;
  } timer_state_t;

  timer_state_t cur;
  timer_state_t next_cur;
  logic start_sync;

  sync3 #(
    .WIDTH(1)
  ) u_start_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(start_toggle_in),
    .sync_out(start_sync)
  );

  always_comb begin
    next_cur = cur;
    if (start_sync != cur.seen) begin
      next_cur.seen = start_sync;
      next_cur.busy = 1'b1;
      next_cur.count = CW'(WRITE_CYCLES - 1);
    end else if (cur.busy) begin
      if (cur.count == '0) begin
        next_cur.busy = 1'b0;
        next_cur.done = ~cur.done;
      end else begin
        next_cur.count = cur.count - CW'(1);
      end
    end
    if (!rst_n_in) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    cur <= next_cur;
  end

  assign busy_out = cur.busy;
  assign done_toggle_out = cur.done;

endmodule

`default_nettype wire
